// ---- design/input_filter.sv ----
/*
 * Digital glitch filter for one encoder input.
 * Assumes the input is already synchronised to clk_sys.
 */
module input_filter
	import qenc_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Control
	input  wire logic enable,
	input  wire logic sample_tick,
	// Signal
	input  wire logic din,
	output logic      dout
);

	logic [FILTER_TAPS-1:0] hist_r;
	logic                   held_r;

	// A level passes only after it was stable over all filter samples.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hist_r <= '0;
			held_r <= 1'b0;
		end else if (sample_tick) begin
			hist_r <= {hist_r[FILTER_TAPS-2:0], din};
			if (&hist_r)
				held_r <= 1'b1;
			else if (~|hist_r)
				held_r <= 1'b0;
		end
	end

	assign dout = enable ? held_r : din;

endmodule : input_filter

// ---- design/pow2_divider.sv ----
/*
 * Power-of-two clock enable divider.
 * Assumes a free running system clock; code 0 gives an enable every cycle.
 */
module pow2_divider
	import qenc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Division select
	input  wire logic [2:0] div_code,
	// Enable out
	output logic            tick
);

	logic [6:0] count_r;
	logic [6:0] mask;

	assign mask = 7'(({7'h00, 1'b1} << div_code) - 8'h01);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= 7'h00;
			tick    <= 1'b0;
		end else begin
			count_r <= 7'(count_r + 7'h01) & mask;
			tick    <= ((count_r & mask) == mask);
		end
	end

endmodule : pow2_divider

// ---- design/qenc_pkg.sv ----
/*
 * Constants, register layout and carrier types of the quadrature encoder control block.
 * Assumes a single 125 MHz system clock and a plain strobe register port.
 */
// What this block does
// - Counter clock divides by 1 to 128 from a 3-bit prescale code.
// - One prescaled clock drives the position counter, in timer mode only.
// - Direction bit clear: count positive unless phase order (quadrature mode) or external up/down reverses.
// - Gate enable set lets the external gate stop counting; clear ignores it.
// - Mode field picks quadrature x4, ext clock with dir, ext clock, or timer.
// - Modes 10 and 11 ignore position init mode; only mode 11 runs as a timer, mode 10 counts ext clock edges.
// - In quadrature mode a phase match with index value resets the position count.
// - Index match uses phases after swap and polarity inversion.
// - Filter enable filters phase, index and home inputs; clear bypasses them.
package qenc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_IO_CTRL  = 4'h4;
	localparam logic [3:0] ADDR_POS_LOW  = 4'h8;
	localparam logic [3:0] ADDR_POS_HIGH = 4'hC;

	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] IO_CTRL_RESET = 16'h0000;
	localparam logic [15:0] IO_CTRL_WMASK = 16'hFFF0;

	// Control register fields.
	localparam int POS_INIT_LSB  = 8;
	localparam int PRESCALE_LSB  = 4;
	localparam int DIR_SEL_BIT   = 3;
	localparam int GATE_EN_BIT   = 2;
	localparam int MODE_LSB      = 0;
	localparam int INDEX_MATCH_LSB = 12;

	// I/O control register fields.
	localparam int CAPTURE_EN_BIT = 15;
	localparam int FILTER_EN_BIT  = 14;
	localparam int FILTER_DIV_LSB = 11;
	localparam int SWAP_BIT       = 8;
	localparam int HOME_POL_BIT   = 7;
	localparam int INDEX_POL_BIT  = 6;
	localparam int PHB_POL_BIT    = 5;
	localparam int PHA_POL_BIT    = 4;

	localparam int FILTER_TAPS = 3;

	typedef enum logic [1:0] {
		MODE_QUAD_X4   = 2'b00,
		MODE_EXT_DIR   = 2'b01,
		MODE_EXT_COUNT = 2'b10,
		MODE_TIMER     = 2'b11
	} counter_mode_t;

	// Encoder pins after synchronising.
	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic index;
		logic home;
	} enc_pins_t;

endpackage : qenc_pkg

// ---- design/quadrature_encoder_control.sv ----
/*
 * Quadrature encoder control: registers, input conditioning, mode select and position counter.
 * Assumes encoder pins are asynchronous and the register master follows the strobe port.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module quadrature_encoder_control
	import qenc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	// Encoder pins
	input  wire logic        phase_a_input,
	input  wire logic        phase_b_input,
	input  wire logic        index_input,
	input  wire logic        home_input,
	// External count sources
	input  wire logic        ext_clock_input,
	input  wire logic        ext_up_down_input,
	input  wire logic        ext_gate_input,
	// Status
	output logic      [31:0] position_count,
	output logic             count_tick,
	output logic             index_match_pulse
);

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] control_r;
	logic [15:0] io_ctrl_r;
	logic [31:0] pos_r;
	logic [31:0] pos_nxt;

	logic [2:0]    timer_clock_prescale;
	logic          count_direction_select;
	logic          external_gate_enable;
	counter_mode_t counter_mode_select;
	logic [2:0]    position_init_mode;
	logic [1:0]    index_match_value;
	logic          index_capture_enable;
	logic          input_filter_enable;
	logic [2:0]    filter_clock_divide;
	logic          phase_swap;
	logic          phase_a_polarity;
	logic          phase_b_polarity;
	logic          home_polarity;
	logic          index_polarity;

	assign timer_clock_prescale   = control_r[PRESCALE_LSB +: 3];
	assign count_direction_select = control_r[DIR_SEL_BIT];
	assign external_gate_enable   = control_r[GATE_EN_BIT];
	assign counter_mode_select    = counter_mode_t'(control_r[MODE_LSB +: 2]);
	assign position_init_mode     = control_r[POS_INIT_LSB +: 3];
	assign index_match_value      = control_r[INDEX_MATCH_LSB +: 2];
	assign index_capture_enable   = io_ctrl_r[CAPTURE_EN_BIT];
	assign input_filter_enable    = io_ctrl_r[FILTER_EN_BIT];
	assign filter_clock_divide    = io_ctrl_r[FILTER_DIV_LSB +: 3];
	assign phase_swap             = io_ctrl_r[SWAP_BIT];
	assign home_polarity          = io_ctrl_r[HOME_POL_BIT];
	assign index_polarity         = io_ctrl_r[INDEX_POL_BIT];
	assign phase_b_polarity       = io_ctrl_r[PHB_POL_BIT];
	assign phase_a_polarity       = io_ctrl_r[PHA_POL_BIT];

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic reg_hit(input logic       strobe,
	                                 input logic [3:0] addr,
	                                 input logic [3:0] target);
		return strobe && (addr == target);
	endfunction : reg_hit

	// ****************************************
	// Elaboration checks
	// ****************************************
	// The writable io fields must stay clear of the read-only status nibble.
	if (PHA_POL_BIT < 4) begin : g_status_overlap
		$error("io control fields overlap the status bits");
	end

	// Every control field must fit inside the 16-bit register.
	if (INDEX_MATCH_LSB + 2 > 16 || POS_INIT_LSB + 3 > 16) begin : g_ctrl_overflow
		$error("control fields run past the register width");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int NPINS = 7;
	logic [NPINS-1:0] pins_raw;
	logic [NPINS-1:0] sync1_r;
	logic [NPINS-1:0] sync2_r;

	assign pins_raw = {ext_gate_input, ext_up_down_input, ext_clock_input,
	                   home_input, index_input, phase_b_input, phase_a_input};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	// ****************************************
	// Filters
	// ****************************************
	logic      filter_tick;
	logic [3:0] filt;
	enc_pins_t pins;

	pow2_divider u_filter_div (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.div_code (filter_clock_divide),
		.tick     (filter_tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			input_filter u_filt (
				.clk_sys     (clk_sys),
				.rst_n       (rst_n),
				.enable      (input_filter_enable),
				.sample_tick (filter_tick),
				.din         (sync2_r[gi]),
				.dout        (filt[gi])
			);
		end
	endgenerate

	// Swap first, then polarity, so the match sees the decoder's view.
	always_comb begin
		pins.phase_a = (phase_swap ? filt[1] : filt[0]) ^ phase_a_polarity;
		pins.phase_b = (phase_swap ? filt[0] : filt[1]) ^ phase_b_polarity;
		pins.index   = filt[2] ^ index_polarity;
		pins.home    = filt[3] ^ home_polarity;
	end

	// ****************************************
	// Prescaled counter clock
	// ****************************************
	logic prescale_tick;

	// This enable steps the position counter in timer mode only.
	pow2_divider u_prescale (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.div_code (timer_clock_prescale),
		.tick     (prescale_tick)
	);

	// ****************************************
	// Edge detection
	// ****************************************
	logic a_q_r;
	logic b_q_r;
	logic ext_clk_q_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			a_q_r       <= 1'b0;
			b_q_r       <= 1'b0;
			ext_clk_q_r <= 1'b0;
		end else begin
			a_q_r       <= pins.phase_a;
			b_q_r       <= pins.phase_b;
			ext_clk_q_r <= sync2_r[4];
		end
	end

	logic io_write;
	logic io_settle_r;

	// A swap, polarity or filter write flips the decoded phases at once; the cycle
	// after such a write is not decoded, so the flip is not taken for a step.
	// A genuine phase edge in that one cycle is dropped as well.
	assign io_write = reg_hit(reg_write, reg_addr, ADDR_IO_CTRL);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			io_settle_r <= 1'b0;
		else
			io_settle_r <= io_write;
	end

	logic quad_step;
	logic quad_up;
	logic ext_rise;

	// X4 decode: any single phase edge is one step; direction from phase order.
	assign quad_step = ((pins.phase_a ^ a_q_r) ^ (pins.phase_b ^ b_q_r)) & ~io_settle_r;
	assign quad_up   = pins.phase_a ^ b_q_r;
	assign ext_rise  = sync2_r[4] & ~ext_clk_q_r;

	// ****************************************
	// Count step selection
	// ****************************************
	logic step;
	logic up_raw;
	logic gate_ok;
	logic timer_mode;

	assign gate_ok    = ~external_gate_enable | sync2_r[6];
	assign timer_mode = (counter_mode_select == MODE_EXT_COUNT) ||
	                    (counter_mode_select == MODE_TIMER);

	always_comb begin
		step   = 1'b0;
		up_raw = 1'b1;
		case (counter_mode_select)
			MODE_QUAD_X4: begin
				step   = quad_step;
				up_raw = quad_up;
			end
			MODE_EXT_DIR: begin
				step   = ext_rise;
				up_raw = sync2_r[5];
			end
			MODE_EXT_COUNT: begin
				step   = ext_rise;
				up_raw = 1'b1;
			end
			MODE_TIMER: begin
				step   = prescale_tick;
				up_raw = 1'b1;
			end
			default: begin
				step   = 1'b0;
				up_raw = 1'b1;
			end
		endcase
	end

	logic count_up;
	logic do_step;
	logic match;

	assign count_up = up_raw ^ count_direction_select;
	assign do_step  = step & gate_ok;
	assign match    = (counter_mode_select == MODE_QUAD_X4) &&
	                  ({pins.phase_b, pins.phase_a} == index_match_value);

	// ****************************************
	// Position counter
	// ****************************************
	logic wr_low;
	logic wr_high;

	assign wr_low  = reg_hit(reg_write, reg_addr, ADDR_POS_LOW);
	assign wr_high = reg_hit(reg_write, reg_addr, ADDR_POS_HIGH);

	always_comb begin
		pos_nxt = pos_r;
		if (wr_low)
			pos_nxt[15:0] = reg_wdata;
		if (wr_high)
			pos_nxt[31:16] = reg_wdata;
		if (match)
			pos_nxt = 32'h0000_0000;
		else if (do_step)
			pos_nxt = count_up ? pos_r + 32'h0000_0001 : pos_r - 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			pos_r <= 32'h0000_0000;
		else
			pos_r <= pos_nxt;
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			control_r <= CONTROL_RESET;
		else if (reg_hit(reg_write, reg_addr, ADDR_CONTROL))
			control_r <= reg_wdata;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			io_ctrl_r <= IO_CTRL_RESET;
		else if (io_write)
			io_ctrl_r <= reg_wdata & IO_CTRL_WMASK;
	end

	// ****************************************
	// Read port and outputs
	// ****************************************
	logic [15:0] ctrl_view;

	// In timer modes the position init field reads and acts as zero.
	assign ctrl_view = timer_mode ?
	                   (control_r & ~(16'h0007 << POS_INIT_LSB)) : control_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_read) begin
			case (reg_addr)
				ADDR_CONTROL:  reg_rdata <= ctrl_view;
				ADDR_IO_CTRL:  reg_rdata <= {io_ctrl_r[15:4], pins.home, pins.index,
				                             pins.phase_b, pins.phase_a};
				ADDR_POS_LOW:  reg_rdata <= pos_r[15:0];
				ADDR_POS_HIGH: reg_rdata <= pos_r[31:16];
				default:       reg_rdata <= 16'h0000;
			endcase
		end else
			reg_rdata <= 16'h0000;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			position_count <= 32'h0000_0000;
		else
			position_count <= pos_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			count_tick <= 1'b0;
		else
			count_tick <= do_step & ~match;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			index_match_pulse <= 1'b0;
		else
			index_match_pulse <= match & index_capture_enable;
	end

	logic unused_ok;
	assign unused_ok = &{1'b0, position_init_mode};

endmodule : quadrature_encoder_control

// ---- test/encoder_model.sv ----
/*
 * Partner model: an incremental encoder driving phase, index and home pins.
 * Assumes the bench calls move from its main sequence, one call at a time.
 */
module encoder_model (
	// Clock
	input  wire logic clk_sys,
	// Encoder pins
	output logic      phase_a,
	output logic      phase_b,
	output logic      index,
	output logic      home
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] pos = 32'h0;
	assign phase_a = pos[1] ^ pos[0];
	assign phase_b = pos[1];
	assign index   = pos[1:0] == 2'b00;
	assign home    = pos[2];
	// Each state is held eight cycles, well below the counter clock rate.
	task move(input int n);
		repeat (n < 0 ? -n : n) begin
			repeat (8) @(posedge clk_sys);
			pos <= pos + (n < 0 ? 32'hFFFFFFFF : 32'h1);
		end
		repeat (8) @(posedge clk_sys);
	endtask : move
endmodule : encoder_model

// ---- test/quadrature_encoder_control_properties.sv ----
/*
 * Port checker of the quadrature encoder control block.
 * Assumes it is bound to the top module and sees only its ports.
 */
module qenc_properties
	import qenc_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Register port
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	// Pins and status
	input wire logic        ext_gate_input,
	input wire logic [31:0] position_count,
	input wire logic        count_tick,
	input wire logic        index_match_pulse
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [15:0] ctrl_r, io_r;
	logic [9:0]  quiet_r;
	logic [8:0]  gap_r, glo_r;
	logic        timer_mode;
	assign timer_mode = ctrl_r[1:0] == 2'b11;
	// ****************************************
	// Shadow registers and counters
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CONTROL_RESET;
			io_r   <= IO_CTRL_RESET;
		end else if (reg_write && reg_addr == ADDR_CONTROL) begin
			ctrl_r <= reg_wdata;
		end else if (reg_write && reg_addr == ADDR_IO_CTRL) begin
			io_r <= reg_wdata;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			quiet_r <= 10'h000;
			gap_r   <= 9'h000;
			glo_r   <= 9'h000;
		end else begin
			quiet_r <= reg_write ? 10'h000 : quiet_r + {9'h000, quiet_r != 10'h3FF};
			gap_r   <= count_tick ? 9'h000 : gap_r + {8'h00, gap_r != 9'h1FF};
			glo_r   <= ext_gate_input ? 9'h000 : glo_r + {8'h00, glo_r != 9'h1FF};
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	unmapped_read_a: assert property ($past(reg_read) && $past(reg_addr[1:0]) != 2'b00
		|-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
	ctrl_readback_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_CONTROL
		|-> (reg_rdata & 16'h377F) == ($past(ctrl_r) & ($past(ctrl_r[1]) ? 16'h307F : 16'h377F)))
		else $error("control read back wrong");
	io_readback_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_IO_CTRL
		|-> (reg_rdata & IO_CTRL_WMASK) == ($past(io_r) & IO_CTRL_WMASK))
		else $error("io control read back wrong");
	timer_period_a: assert property (count_tick && timer_mode && !ctrl_r[GATE_EN_BIT]
		&& quiet_r > gap_r + 16 |-> gap_r == (9'h001 << ctrl_r[6:4]) - 9'h001)
		else $error("timer tick spacing wrong");
	timer_dir_a: assert property ($changed(position_count) && timer_mode && quiet_r > 10'd8
		|-> position_count == $past(position_count) + (ctrl_r[DIR_SEL_BIT] ? 32'hFFFFFFFF : 32'h1))
		else $error("timer step size or sense wrong");
	gate_hold_a: assert property (ctrl_r[GATE_EN_BIT] && ctrl_r[1] && glo_r > 9'd8
		&& quiet_r > 10'd8 |-> $stable(position_count)) else $error("count moved while gated");
	match_reset_a: assert property (ctrl_r[1:0] == 2'b00 && quiet_r > 10'd8
		&& index_match_pulse && $past(index_match_pulse) |-> position_count == 32'h0)
		else $error("position not cleared on index match");
	capture_only_a: assert property (index_match_pulse |-> $past(io_r[CAPTURE_EN_BIT]))
		else $error("match pulse without capture enable");
	cover property (count_tick && timer_mode);
	cover property (index_match_pulse);
	cover property ($past(reg_read) && reg_rdata != 16'h0000);
endmodule : qenc_properties

// ---- test/quadrature_encoder_control_tb.sv ----
/*
 * Self-checking bench of the quadrature encoder control block.
 * Assumes the encoder model and the port checker are compiled first.
 */
module quadrature_encoder_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import qenc_pkg::*;
	logic        clk_sys = 0, rst_n = 0, reg_write = 0, reg_read = 0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
	logic        phase_a_input, phase_b_input, index_input, home_input;
	logic        ext_clock_input = 0, ext_up_down_input = 0, ext_gate_input = 0;
	logic        count_tick, index_match_pulse;
	logic [31:0] position_count, v;
	int          n_errors = 0, cmp_count = 0, n;
	always #4 clk_sys = ~clk_sys;
	encoder_model enc (.clk_sys, .phase_a(phase_a_input), .phase_b(phase_b_input),
		.index(index_input), .home(home_input));
	quadrature_encoder_control dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .phase_a_input, .phase_b_input, .index_input, .home_input,
		.ext_clock_input, .ext_up_down_input, .ext_gate_input, .position_count,
		.count_tick, .index_match_pulse);
	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task w(input int k);
		repeat (k) @(posedge clk_sys);
	endtask : w
	task wr(input logic [3:0] a, input logic [15:0] x);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= x;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask : wr
	task rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		@(posedge clk_sys);
		chk({16'h0000, reg_rdata & m}, {16'h0000, e});
	endtask : rc
	task adv(input logic [31:0] e);
		w(10);
		v = position_count;
		w(10);
		chk(position_count, v + e);
	endtask : adv
	task gap(output int g);
		int k;
		k = 0;
		while (count_tick !== 1'b1 && k < 300) begin
			@(posedge clk_sys);
			k++;
		end
		g = 0;
		do begin
			@(posedge clk_sys);
			g++;
		end while (count_tick !== 1'b1 && g < 300);
	endtask : gap
	task pulses(input logic [31:0] e);
		// The mode write can still land one step of the old mode; let it settle.
		w(2);
		v = position_count;
		repeat (5) begin
			ext_clock_input <= 1'b1;
			w(4);
			ext_clock_input <= 1'b0;
			w(4);
		end
		w(8);
		chk(position_count, v + e);
	endtask : pulses
	task stat(input logic [15:0] io, input logic [15:0] e);
		wr(ADDR_IO_CTRL, io);
		w(8);
		rc(ADDR_IO_CTRL, 16'h000F, e);
	endtask : stat
	task results;
		$display("TB: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		w(16);
		rst_n <= 1'b1;
		w(2);
		rc(ADDR_CONTROL, 16'hFFFF, CONTROL_RESET);
		rc(ADDR_IO_CTRL, 16'hFFF0, IO_CTRL_RESET);
		wr(4'h2, 16'hFFFF);
		rc(4'h2, 16'hFFFF, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CONTROL, 16'h0500 | m);
			rc(ADDR_CONTROL, 16'h0703, m[1] ? m : 16'h0500 | m);
		end
		$display("TB: register test done");
		for (int p = 0; p < 8; p++) begin
			wr(ADDR_CONTROL, 16'h0003 | (p << 4));
			repeat (3) gap(n);
			chk(n, 1 << p);
		end
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CONTROL, 16'h0003 | (s << 3));
			adv(s ? -10 : 10);
		end
		wr(ADDR_CONTROL, 16'h0007);
		adv(0);
		ext_gate_input <= 1'b1;
		adv(10);
		wr(ADDR_CONTROL, 16'h0003);
		ext_gate_input <= 1'b0;
		adv(10);
		$display("TB: timer test done");
		wr(ADDR_CONTROL, 16'h0001);
		ext_up_down_input <= 1'b1;
		pulses(5);
		ext_up_down_input <= 1'b0;
		pulses(-5);
		wr(ADDR_CONTROL, 16'h0002);
		ext_up_down_input <= 1'b1;
		pulses(5);
		wr(ADDR_CONTROL, 16'h000A);
		pulses(-5);
		$display("TB: external count test done");
		wr(ADDR_IO_CTRL, 16'h8000);
		wr(ADDR_CONTROL, 16'h0000);
		w(10);
		chk(position_count, 32'h0);
		enc.move(3);
		chk(position_count, 32'h3);
		enc.move(1);
		chk(position_count, 32'h0);
		chk(index_match_pulse, 1);
		wr(ADDR_IO_CTRL, 16'h8010);
		wr(ADDR_CONTROL, 16'h1000);
		w(10);
		chk(position_count, 32'h0);
		enc.move(3);
		chk(position_count, 32'hFFFFFFFD);
		enc.move(1);
		chk(position_count, 32'h0);
		$display("TB: index match test done");
		for (int c = 0; c < 8; c += 7) begin
			wr(ADDR_IO_CTRL, 16'h4000 | (c << 11));
			enc.move(1);
			rc(ADDR_IO_CTRL, 16'h0001, c ? 16'h0000 : 16'h0001);
			w(600);
			rc(ADDR_IO_CTRL, 16'h0001, 16'h0001);
			enc.move(-1);
			w(600);
		end
		wr(ADDR_IO_CTRL, 16'h0000);
		enc.move(1);
		stat(16'h0000, 16'h0001);
		stat(16'h0010, 16'h0000);
		stat(16'h0100, 16'h0002);
		stat(16'h00C0, 16'h000D);
		enc.move(-5);
		stat(16'h0000, 16'h000C);
		$display("TB: input test done");
		results;
	end
	initial begin
		#400000;
		n_errors++;
		results;
	end
endmodule : quadrature_encoder_control_tb
bind quadrature_encoder_control qenc_properties chk_i (.clk_sys, .rst_n, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .ext_gate_input, .position_count,
	.count_tick, .index_match_pulse);
